// ==== ubr_map.svh ====
`ifndef UBR_MAP_SVH
`define UBR_MAP_SVH
`define UBR_AD_W        32
`define UBR_CBE_W       4
`define UBR_PIN_W       6
`define UBR_PIN_GNT     0
`define UBR_PIN_FRAME   1
`define UBR_PIN_IRDY    2
`define UBR_PIN_RST     3
`define UBR_PIN_USTRAP  4
`define UBR_PIN_DSTRAP  5
`define UBR_PIN_RESET   6'h3f
`define UBR_GAP_CYCLES  2'h2
`define UBR_GAP_ZERO    2'h0
`define UBR_GAP_ONE     2'h1
`define UBR_PARK_AD     32'h0000_0000
`define UBR_PARK_CBE    4'h0
`endif

// ==== ubr_pkg.sv ====
package ubr_pkg;
	typedef enum logic [1:0] {
		UBR_IDLE,
		UBR_REQ,
		UBR_OWN
	} ubr_state_e;
	typedef logic [1:0] ubr_gap_t;
endpackage

// ==== ubr_port.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ubr_map.svh"
// Operation
// - request goes low while the user side wants a transaction.
// - a withdrawn request stays high three clocks before it returns.
// - the bus is taken only while the filtered grant is low.
// - idle bus and low grant park the address, command and parity lines.
// - a low bus reset pin clears every output enable at once.
// - a high upstream speed strap reports 66 MHz capable operation.
// - a low upstream strap with a high downstream strap flags a conflict.
module ubr_port
	import ubr_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	input  wire logic                  upstream_rst_n,
	input  wire logic                  upstream_gnt_n,
	input  wire logic                  upstream_frame_n,
	input  wire logic                  upstream_irdy_n,
	input  wire logic                  upstream_speed_strap,
	input  wire logic                  downstream_speed_strap,
	input  wire logic                  xact_req,
	input  wire logic [`UBR_AD_W-1:0]  xact_addr,
	input  wire logic [`UBR_CBE_W-1:0] xact_cmd,
	input  wire logic                  xact_end,
	output logic                       upstream_req_n,
	output logic                       upstream_req_oe,
	output logic [`UBR_AD_W-1:0]       upstream_ad_out,
	output logic                       upstream_ad_oe,
	output logic [`UBR_CBE_W-1:0]      upstream_cmd_byte_en,
	output logic                       upstream_cmd_byte_en_oe,
	output logic                       upstream_parity,
	output logic                       upstream_parity_oe,
	output logic                       xact_start,
	output logic                       bus_owner,
	output logic                       speed_66,
	output logic                       strap_conflict
);
	function automatic logic [`UBR_PIN_W-1:0] agree(
		input logic [`UBR_PIN_W-1:0] a,
		input logic [`UBR_PIN_W-1:0] b,
		input logic [`UBR_PIN_W-1:0] held
	);
		agree = (~(a ^ b) & a) | ((a ^ b) & held);
	endfunction

	function automatic logic even_par(
		input logic [`UBR_AD_W-1:0]  ad,
		input logic [`UBR_CBE_W-1:0] cbe
	);
		even_par = ^{ad, cbe};
	endfunction

	// pin synchronisers, three stages, second and third must agree
	logic [`UBR_PIN_W-1:0] pin_s1;
	logic [`UBR_PIN_W-1:0] pin_s2;
	logic [`UBR_PIN_W-1:0] pin_s3;
	logic [`UBR_PIN_W-1:0] pin_filt;
	logic [`UBR_PIN_W-1:0] pin_raw;
	logic [`UBR_PIN_W-1:0] next_pin_s1;
	logic [`UBR_PIN_W-1:0] next_pin_s2;
	logic [`UBR_PIN_W-1:0] next_pin_s3;
	logic [`UBR_PIN_W-1:0] next_pin_filt;

	always_comb begin
		pin_raw = {downstream_speed_strap, upstream_speed_strap,
			upstream_rst_n, upstream_irdy_n, upstream_frame_n,
			upstream_gnt_n};
		if (srst) begin
			next_pin_s1   = `UBR_PIN_RESET;
			next_pin_s2   = `UBR_PIN_RESET;
			next_pin_s3   = `UBR_PIN_RESET;
			next_pin_filt = `UBR_PIN_RESET;
		end else begin
			next_pin_s1   = pin_raw;
			next_pin_s2   = pin_s1;
			next_pin_s3   = pin_s2;
			next_pin_filt = agree(pin_s2, pin_s3, pin_filt);
		end
	end

	always_ff @(posedge ref_clk) begin
		pin_s1   <= next_pin_s1;
		pin_s2   <= next_pin_s2;
		pin_s3   <= next_pin_s3;
		pin_filt <= next_pin_filt;
	end

	logic gnt_ok;
	logic bus_idle;
	logic bus_rst;
	assign gnt_ok   = ~pin_filt[`UBR_PIN_GNT];
	assign bus_idle = pin_filt[`UBR_PIN_FRAME] & pin_filt[`UBR_PIN_IRDY];
	assign bus_rst  = ~pin_filt[`UBR_PIN_RST];

	// straps are caught while the bus reset is held
	logic next_speed_66;
	logic next_strap_conflict;

	always_comb begin
		next_speed_66       = speed_66;
		next_strap_conflict = strap_conflict;
		if (srst) begin
			next_speed_66       = 1'b0;
			next_strap_conflict = 1'b0;
		end else if (bus_rst) begin
			next_speed_66       = pin_filt[`UBR_PIN_USTRAP];
			next_strap_conflict = ~pin_filt[`UBR_PIN_USTRAP] &
				pin_filt[`UBR_PIN_DSTRAP];
		end
	end

	always_ff @(posedge ref_clk) begin
		speed_66       <= next_speed_66;
		strap_conflict <= next_strap_conflict;
	end

	// request and ownership sequencing
	ubr_state_e state;
	ubr_state_e next_state;
	ubr_gap_t   gap_cnt;
	ubr_gap_t   next_gap_cnt;
	logic       next_req_n;
	logic       next_xact_start;
	logic       next_bus_owner;

	always_comb begin
		next_state      = state;
		next_req_n      = upstream_req_n;
		next_xact_start = 1'b0;
		next_bus_owner  = bus_owner;
		next_gap_cnt    = gap_cnt;
		if (upstream_req_n && gap_cnt != `UBR_GAP_CYCLES) begin
			next_gap_cnt = gap_cnt + `UBR_GAP_ONE;
		end
		if (srst || bus_rst) begin
			next_state     = UBR_IDLE;
			next_req_n     = 1'b1;
			next_bus_owner = 1'b0;
			next_gap_cnt   = `UBR_GAP_CYCLES;
		end else begin
			case (state)
				UBR_IDLE: begin
					if (xact_req && gap_cnt == `UBR_GAP_CYCLES) begin
						next_state = UBR_REQ;
						next_req_n = 1'b0;
					end
				end
				UBR_REQ: begin
					if (!xact_req) begin
						next_state   = UBR_IDLE;
						next_req_n   = 1'b1;
						next_gap_cnt = `UBR_GAP_ZERO;
					end else if (gnt_ok && bus_idle) begin
						next_state      = UBR_OWN;
						next_req_n      = 1'b1;
						next_gap_cnt    = `UBR_GAP_ZERO;
						next_xact_start = 1'b1;
						next_bus_owner  = 1'b1;
					end
				end
				UBR_OWN: begin
					if (xact_end) begin
						next_state     = UBR_IDLE;
						next_bus_owner = 1'b0;
					end
				end
				default: begin
					next_state     = UBR_IDLE;
					next_req_n     = 1'b1;
					next_bus_owner = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		state          <= next_state;
		gap_cnt        <= next_gap_cnt;
		upstream_req_n <= next_req_n;
		xact_start     <= next_xact_start;
		bus_owner      <= next_bus_owner;
	end

	// bus drivers: own cycle drives the user address, idle with grant parks
	logic [`UBR_AD_W-1:0]  next_ad;
	logic [`UBR_CBE_W-1:0] next_cbe;
	logic                  next_par;
	logic                  next_drive;
	logic                  next_req_oe;

	always_comb begin
		next_ad     = upstream_ad_out;
		next_cbe    = upstream_cmd_byte_en;
		next_drive  = 1'b0;
		next_req_oe = ~(srst | bus_rst);
		if (srst || bus_rst) begin
			next_ad  = `UBR_PARK_AD;
			next_cbe = `UBR_PARK_CBE;
		end else if (next_bus_owner) begin
			next_drive = 1'b1;
			if (next_xact_start) begin
				next_ad  = xact_addr;
				next_cbe = xact_cmd;
			end
		end else if (gnt_ok && bus_idle) begin
			next_drive = 1'b1;
			next_ad    = `UBR_PARK_AD;
			next_cbe   = `UBR_PARK_CBE;
		end
		next_par = even_par(next_ad, next_cbe);
	end

	always_ff @(posedge ref_clk) begin
		upstream_ad_out      <= next_ad;
		upstream_cmd_byte_en <= next_cbe;
		upstream_parity      <= next_par;
	end

	// enables clear at once on the bus reset pin
	always_ff @(posedge ref_clk or negedge upstream_rst_n) begin
		if (!upstream_rst_n) begin
			upstream_ad_oe          <= 1'b0;
			upstream_cmd_byte_en_oe <= 1'b0;
			upstream_parity_oe      <= 1'b0;
			upstream_req_oe         <= 1'b0;
		end else begin
			upstream_ad_oe          <= next_drive;
			upstream_cmd_byte_en_oe <= next_drive;
			upstream_parity_oe      <= next_drive;
			upstream_req_oe         <= next_req_oe;
		end
	end
endmodule
`default_nettype wire

// ==== ubr_port_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubr_port_checker (
	input wire logic	ref_clk,
	input wire logic	srst,
	input wire logic	upstream_rst_n,
	input wire logic	upstream_gnt_n,
	input wire logic	upstream_frame_n,
	input wire logic	upstream_irdy_n,
	input wire logic	upstream_speed_strap,
	input wire logic	xact_req,
	input wire logic [31:0]	xact_addr,
	input wire logic	upstream_req_n,
	input wire logic [31:0]	upstream_ad_out,
	input wire logic	upstream_ad_oe,
	input wire logic	upstream_parity,
	input wire logic	xact_start,
	input wire logic	bus_owner,
	input wire logic	speed_66
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	req_asks_a: assert property (
		(upstream_rst_n && upstream_req_n && !bus_owner) [*8] ##0 xact_req
		|=> !upstream_req_n) else $error("request not raised");
	gap_hold_a: assert property (
		$rose(upstream_req_n) |-> upstream_req_n [*2]) else $error("short gap");
	start_gnt_a: assert property (
		$rose(xact_start) |-> !$past(upstream_gnt_n, 4)) else $error("no grant");
	start_idle_a: assert property (
		$rose(xact_start) |-> $past(upstream_frame_n, 4)
		&& $past(upstream_irdy_n, 4)) else $error("bus not idle");
	start_drive_a: assert property (
		$rose(xact_start) |-> upstream_ad_oe
		&& upstream_ad_out == $past(xact_addr)) else $error("bad address");
	bus_park_a: assert property (
		(!bus_owner && !upstream_gnt_n && upstream_frame_n && upstream_irdy_n
		&& upstream_rst_n) [*6] |-> upstream_ad_oe && upstream_ad_out == 0
		&& !upstream_parity) else $error("bus not parked");
	bus_float_a: assert property (
		!upstream_rst_n |-> !upstream_ad_oe) else $error("bus driven");
	speed_strap_a: assert property (
		(!upstream_rst_n && $stable(upstream_speed_strap)) [*8]
		|-> speed_66 == upstream_speed_strap) else $error("bad speed");
endmodule
bind ubr_port ubr_port_checker chk_u (.*);
`default_nettype wire

// ==== ubr_arb_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubr_arb_model (
	input wire logic	ref_clk,
	input wire logic	upstream_req_n,
	input wire logic	park,
	input wire logic	other_busy,
	input wire logic [2:0]	delay,
	output logic	upstream_gnt_n = 1'b1,
	output logic	upstream_frame_n = 1'b1,
	output logic	upstream_irdy_n = 1'b1
);
	logic [2:0] wait_cnt = 3'h0;
	always @(posedge ref_clk) begin
		upstream_frame_n <= !other_busy;
		upstream_irdy_n <= !other_busy;
		wait_cnt <= upstream_req_n ? 3'h0 : wait_cnt + {2'h0, wait_cnt != 3'h7};
		if (other_busy)
			upstream_gnt_n <= 1'b1;
		else if (!upstream_req_n)
			upstream_gnt_n <= wait_cnt < delay;
		else
			upstream_gnt_n <= !park;
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0, srst = 1'b1, upstream_rst_n = 1'b0, park = 1'b0;
	logic upstream_speed_strap = 1'b0, downstream_speed_strap = 1'b0;
	logic xact_req = 1'b0, xact_end = 1'b0, other_busy = 1'b0;
	logic [31:0] xact_addr = 32'h0, upstream_ad_out;
	logic [3:0] xact_cmd = 4'h0, upstream_cmd_byte_en;
	logic [2:0] delay = 3'h0;
	logic upstream_gnt_n, upstream_frame_n, upstream_irdy_n, upstream_req_n;
	logic upstream_req_oe, upstream_ad_oe, upstream_cmd_byte_en_oe;
	logic upstream_parity, upstream_parity_oe, xact_start, bus_owner;
	logic speed_66, strap_conflict;
	int n_errors = 0, samples_checked = 0, seed = 52, i, n;
	ubr_port dut_u (.*);
	ubr_arb_model arb_u (.*);
	always #25 ref_clk = !ref_clk;
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic exp_parity(input logic [31:0] a,
		input logic [3:0] c);
		return ^{a, c};
	endfunction
	function automatic logic exp_conflict(input logic up, dn);
		return !up && dn;
	endfunction
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		srst = 1'b0;
		for (i = 0; i < 4; i++) begin
			{upstream_speed_strap, downstream_speed_strap} = i[1:0];
			repeat (10) @(negedge ref_clk);
			check("speed", speed_66, upstream_speed_strap);
			check("conflict", strap_conflict,
				exp_conflict(upstream_speed_strap, downstream_speed_strap));
		end
		upstream_rst_n = 1'b1;
		park = 1'b1;
		repeat (8) @(negedge ref_clk);
		check("park oe", &{upstream_ad_oe, upstream_req_oe, upstream_parity_oe,
			upstream_cmd_byte_en_oe}, 1);
		check("park", upstream_ad_out | upstream_cmd_byte_en, 0);
		upstream_rst_n = 1'b0;
		#1;
		check("float", {upstream_req_oe, upstream_ad_oe, upstream_parity_oe,
			upstream_cmd_byte_en_oe}, 0);
		@(negedge ref_clk);
		upstream_rst_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		for (i = 0; i < 24; i++) begin
			n = $random(seed);
			{park, delay, other_busy} = n[4:0];
			xact_cmd = n[8:5];
			xact_addr = $random(seed);
			if (i < 2) begin
				{park, delay, other_busy} = i ? 5'h0f : 5'h00;
				xact_addr = i ? 32'hffff_ffff : 32'h0;
			end
			if (i == 2)
				{park, delay, other_busy} = 5'h0e;
			repeat (2) @(negedge ref_clk);
			other_busy = 1'b0;
			xact_req = 1'b1;
			if (i == 2) begin
				@(negedge ref_clk);
				check("req on", upstream_req_n, 0);
				xact_req = 1'b0;
				@(negedge ref_clk);
				xact_req = 1'b1;
				repeat (2) begin
					check("req gap", upstream_req_n, 1);
					@(negedge ref_clk);
				end
			end
			for (n = 0; n < 60 && xact_start !== 1'b1; n++)
				@(negedge ref_clk);
			if (n == 60) begin
				n_errors++;
				complete_run();
			end
			xact_req = 1'b0;
			check("addr", upstream_ad_out, xact_addr);
			check("cmd", upstream_cmd_byte_en, xact_cmd);
			check("par", upstream_parity, exp_parity(xact_addr, xact_cmd));
			check("owner", bus_owner, 1);
			check("req off", upstream_req_n, 1);
			check("own oe", upstream_ad_oe & upstream_parity_oe, 1);
			repeat (i % 3) @(negedge ref_clk);
			xact_end = 1'b1;
			@(negedge ref_clk);
			xact_end = 1'b0;
			check("release", bus_owner, 0);
		end
		complete_run();
	end
endmodule
`default_nettype wire
